/* dbp_regs.svh */
// Constants of the burst engine: burst lengths and buffer sizes
`ifndef DBP_REGS_SVH
`define DBP_REGS_SVH

// ==========================================================================
// Burst lengths selected per command
`define DBP_BC4_BEATS 4'h4
`define DBP_BL8_BEATS 4'h8

// ==========================================================================
// Write data buffer
`define DBP_FIFO_DEPTH 16
`define DBP_DATA_W 16

`endif

/* dbp_pkg.sv */
// Types used by the burst engine; its write buffer uses none of them
package dbp_pkg;

  // ========================================================================
  // Command codes seen on the command port
  typedef enum logic [2:0] {
    DBP_CMD_NOP = 3'h0,
    DBP_CMD_ACT = 3'h1,
    DBP_CMD_RD = 3'h2,
    DBP_CMD_WR = 3'h3,
    DBP_CMD_PRE = 3'h4
  } dbp_cmd_t;

  // ========================================================================
  // Burst engine states, one-hot
  typedef enum logic [2:0] {
    DBP_ST_IDLE = 3'h1,
    DBP_ST_RBURST = 3'h2,
    DBP_ST_WBURST = 3'h4
  } dbp_state_t;

endpackage : dbp_pkg

/* dbp_fifo.sv */
// Write data buffer with valid and ready on both sides
`timescale 1ns/100ps
module dbp_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic in_ready;
    logic [WIDTH-1:0] head;
  } dbp_fifo_st_t;

  dbp_fifo_st_t q_r;
  dbp_fifo_st_t q_nxt;
  logic push;
  logic pop;

  assign push = in_valid_i && q_r.in_ready;
  assign pop = out_ready_i && (q_r.count != '0);
  assign in_ready_o = q_r.in_ready;
  assign out_valid_o = (q_r.count != '0);
  assign out_data_o = q_r.head;

  always_comb begin
    q_nxt = q_r;
    if (push) begin
      q_nxt.mem[q_r.wr_ptr] = in_data_i;
      q_nxt.wr_ptr = q_r.wr_ptr + 1'b1;
    end
    if (pop) begin
      q_nxt.rd_ptr = q_r.rd_ptr + 1'b1;
    end
    q_nxt.count = q_r.count + (AW+1)'(push) - (AW+1)'(pop);
    q_nxt.in_ready = (q_nxt.count != (AW+1)'(DEPTH));
    // Head word is registered so read data leave a flip-flop
    q_nxt.head = q_nxt.mem[q_nxt.rd_ptr];
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      q_r <= '0;
      q_r.in_ready <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  property p_no_overfill;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (q_r.count == (AW+1)'(DEPTH)) |-> !in_ready_o;
  endproperty
  a_no_overfill: assert property (p_no_overfill)
    else $error("buffer offers room while full");

endmodule : dbp_fifo

/* dbp_burst.sv */
// Burst engine: per-command burst length and contained write errors
//
// Notes on behaviour
// R1: A12 low gives 4-beat chop, tCCD 4
// R2: A12 high gives 8 beats, never column
// R3: Length choice works with auto precharge
// R4: Controller spaces PRE after READ: AL+tRTP
// R5: tRTP at least max(4 clocks, 7.5 ns)
// R6: Controller also keeps ACT-to-PRE minimum
// R7: Controller waits tRP before re-activate
// R8: Controller also waits tRC since last ACT
// R9: Data-to-strobe violation corrupts addressed location only
// R10: Write violations never hang the engine
// R11: Strobe violations corrupt only offending write
// R12: Other violations need full reset by controller
// R13: Controller meets strobe timing on shared edges; the model breaks it on purpose for words with bit 16 set
// R14: Length decided per command from A12
`timescale 1ns/100ps
`include "dbp_regs.svh"
module dbp_burst #(
  parameter int DATA_W = `DBP_DATA_W,
  parameter int FIFO_DEPTH = `DBP_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Command port
  input wire logic cmd_valid_i,
  input wire logic [2:0] cmd_i,
  input wire logic [2:0] cmd_bank_i,
  input wire logic [9:0] cmd_col_i,
  input wire logic cmd_a12_i,
  input wire logic cmd_ap_i,
  output logic cmd_ready_o,
  // Write data stream, one word per beat with its strobe-timing flag
  input wire logic wr_valid_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic wr_viol_i,
  output logic wr_ready_o,
  // Beat stream towards the array
  output logic beat_valid_o,
  output logic beat_write_o,
  output logic [2:0] beat_bank_o,
  output logic [9:0] beat_col_o,
  output logic [2:0] beat_idx_o,
  output logic [3:0] beat_len_o,
  output logic beat_last_o,
  output logic beat_ap_o,
  output logic beat_corrupt_o,
  output logic [DATA_W-1:0] beat_data_o,
  input wire logic beat_ready_i
);

  typedef struct packed {
    dbp_pkg::dbp_state_t st;
    logic cmd_ready;
    logic [2:0] bank;
    logic [9:0] col;
    logic [3:0] len;
    logic [2:0] idx;
    logic ap;
    logic corrupt;
    logic b_valid;
    logic b_write;
    logic [2:0] b_bank;
    logic [9:0] b_col;
    logic [3:0] b_len;
    logic [2:0] b_idx;
    logic b_last;
    logic b_ap;
    logic b_corrupt;
    logic [DATA_W-1:0] b_data;
  } dbp_burst_st_t;

  dbp_burst_st_t q_r;
  dbp_burst_st_t q_nxt;
  logic fifo_valid;
  logic [DATA_W:0] fifo_data;
  logic fifo_pop;
  logic can_emit;
  logic is_last;
  logic accept;
  logic wr_viol_beat;

  // ========================================================================
  // Write buffer
  dbp_fifo #(
    .WIDTH(DATA_W + 1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(wr_valid_i),
    .in_data_i({wr_viol_i, wr_data_i}),
    .in_ready_o(wr_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(fifo_pop)
  );

  // ========================================================================
  // Burst control
  assign can_emit = !q_r.b_valid || beat_ready_i;
  assign is_last = ({1'b0, q_r.idx} == (q_r.len - 4'h1));
  assign fifo_pop = (q_r.st == dbp_pkg::DBP_ST_WBURST) && can_emit;
  assign accept = cmd_valid_i && q_r.cmd_ready &&
    ((cmd_i == dbp_pkg::DBP_CMD_RD) || (cmd_i == dbp_pkg::DBP_CMD_WR));
  assign wr_viol_beat = fifo_data[DATA_W];

  always_comb begin
    q_nxt = q_r;
    if (q_r.b_valid && beat_ready_i) begin
      q_nxt.b_valid = 1'b0;
    end
    case (q_r.st)
      dbp_pkg::DBP_ST_IDLE: begin
        // ACT, PRE and NOP need no burst and are taken silently
        if (accept) begin
          q_nxt.bank = cmd_bank_i;
          q_nxt.col = cmd_col_i; // [R2]
          q_nxt.ap = cmd_ap_i; // [R3]
          q_nxt.len = cmd_a12_i ? `DBP_BL8_BEATS : `DBP_BC4_BEATS; // [R1] [R2] [R14]
          q_nxt.idx = 3'h0;
          q_nxt.corrupt = 1'b0; // [R11]
          q_nxt.cmd_ready = 1'b0;
          q_nxt.st = (cmd_i == dbp_pkg::DBP_CMD_RD) ?
            dbp_pkg::DBP_ST_RBURST : dbp_pkg::DBP_ST_WBURST;
        end
      end
      dbp_pkg::DBP_ST_RBURST: begin
        if (can_emit) begin
          q_nxt.b_valid = 1'b1;
          q_nxt.b_write = 1'b0;
          // Beat keeps its own command fields while a new one is taken
          q_nxt.b_bank = q_r.bank;
          q_nxt.b_col = q_r.col;
          q_nxt.b_len = q_r.len; // [R14]
          q_nxt.b_idx = q_r.idx;
          q_nxt.b_last = is_last;
          q_nxt.b_ap = q_r.ap && is_last;
          q_nxt.b_corrupt = 1'b0;
          q_nxt.b_data = '0;
          q_nxt.idx = q_r.idx + 3'h1;
          if (is_last) begin
            q_nxt.st = dbp_pkg::DBP_ST_IDLE;
            q_nxt.cmd_ready = 1'b1;
          end
        end
      end
      dbp_pkg::DBP_ST_WBURST: begin
        if (can_emit && fifo_valid) begin
          // A violation taints this burst's location only
          q_nxt.corrupt = q_r.corrupt | wr_viol_beat; // [R9] [R11]
          q_nxt.b_valid = 1'b1;
          q_nxt.b_write = 1'b1;
          q_nxt.b_bank = q_r.bank;
          q_nxt.b_col = q_r.col;
          q_nxt.b_len = q_r.len; // [R14]
          q_nxt.b_idx = q_r.idx;
          q_nxt.b_last = is_last;
          q_nxt.b_ap = q_r.ap && is_last;
          q_nxt.b_corrupt = q_r.corrupt | wr_viol_beat; // [R9]
          q_nxt.b_data = fifo_data[DATA_W-1:0];
          q_nxt.idx = q_r.idx + 3'h1;
          if (is_last) begin
            q_nxt.st = dbp_pkg::DBP_ST_IDLE; // [R10]
            q_nxt.cmd_ready = 1'b1;
          end
        end
      end
      default: begin
        q_nxt.st = dbp_pkg::DBP_ST_IDLE;
        q_nxt.cmd_ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      q_r <= '0;
      q_r.st <= dbp_pkg::DBP_ST_IDLE;
      q_r.cmd_ready <= 1'b1;
      q_r.len <= `DBP_BL8_BEATS;
      q_r.b_len <= `DBP_BL8_BEATS;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ========================================================================
  // Outputs
  assign cmd_ready_o = q_r.cmd_ready;
  assign beat_valid_o = q_r.b_valid;
  assign beat_write_o = q_r.b_write;
  assign beat_bank_o = q_r.b_bank;
  assign beat_col_o = q_r.b_col;
  assign beat_idx_o = q_r.b_idx;
  assign beat_len_o = q_r.b_len;
  assign beat_last_o = q_r.b_last;
  assign beat_ap_o = q_r.b_ap;
  assign beat_corrupt_o = q_r.b_corrupt;
  assign beat_data_o = q_r.b_data;

  // ========================================================================
  // Checks
  property p_bc4_len;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    accept && !cmd_a12_i |=> q_r.len == 4'h4;
  endproperty
  a_bc4_len: assert property (p_bc4_len) // [R1]
    else $error("A12 low did not give a 4-beat chop");

  property p_bl8_len;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    accept && cmd_a12_i |=> q_r.len == 4'h8;
  endproperty
  a_bl8_len: assert property (p_bl8_len) // [R2]
    else $error("A12 high did not give 8 beats");

  property p_col_kept;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    accept |=> q_r.col == $past(cmd_col_i);
  endproperty
  a_col_kept: assert property (p_col_kept) // [R2]
    else $error("column changed by burst selector");

  property p_ap_kept;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(beat_valid_o && beat_last_o) |-> beat_ap_o == $past(q_r.ap);
  endproperty
  a_ap_kept: assert property (p_ap_kept) // [R3]
    else $error("auto precharge lost on last beat");

  property p_ap_only_last;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    beat_valid_o && !beat_last_o |-> !beat_ap_o;
  endproperty
  a_ap_only_last: assert property (p_ap_only_last) // [R3]
    else $error("auto precharge shown before the last beat");

  property p_last_idx;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    beat_valid_o && beat_last_o |-> {1'b0, beat_idx_o} == beat_len_o - 4'h1;
  endproperty
  a_last_idx: assert property (p_last_idx) // [R1] [R14]
    else $error("last beat index does not match burst length");

  property p_no_hang;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(beat_valid_o && beat_last_o && beat_write_o) |-> cmd_ready_o;
  endproperty
  a_no_hang: assert property (p_no_hang) // [R10]
    else $error("engine not ready after write burst");

  property p_fresh_burst;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    fifo_pop && fifo_valid && (q_r.idx == 3'h0)
      |=> beat_corrupt_o == $past(wr_viol_beat);
  endproperty
  a_fresh_burst: assert property (p_fresh_burst) // [R11]
    else $error("corruption carried into a new burst");

  property p_read_clean;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    beat_valid_o && !beat_write_o |-> !beat_corrupt_o;
  endproperty
  a_read_clean: assert property (p_read_clean) // [R9]
    else $error("read beat flagged corrupt");

endmodule : dbp_burst

/* dbp_ctrl_model.sv */
// Controller model: timed command issue and a write word stream
`timescale 1ns/100ps
module dbp_ctrl_model #(
  parameter int AL = 0,
  parameter int TRTP = 4,
  parameter int TRAS = 15,
  parameter int TRP = 6,
  parameter int TRC = 21
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Command port
  output logic cmd_valid_o,
  output logic [2:0] cmd_o,
  output logic [2:0] cmd_bank_o,
  output logic [9:0] cmd_col_o,
  output logic cmd_a12_o,
  output logic cmd_ap_o,
  input wire logic cmd_ready_i,
  // Write stream
  input wire logic wr_stall_i,
  output logic wr_valid_o,
  output logic [15:0] wr_data_o,
  output logic wr_viol_o,
  input wire logic wr_ready_i
);
  int cyc = 0;
  int t_act[8] = '{default: -99};
  int t_rd[8] = '{default: -99};
  int t_pre[8] = '{default: -99};
  logic [16:0] wq[$];

  initial begin
    {cmd_valid_o, cmd_o, cmd_bank_o, cmd_col_o, cmd_a12_o, cmd_ap_o} = '0;
    {wr_valid_o, wr_data_o, wr_viol_o} = '0;
  end

  always @(posedge clk_sys_i) cyc <= cyc + 1;

  // Released lines show the inverse of their last value
  task automatic idle;
    cmd_valid_o <= 1'b0;
    cmd_o <= ~cmd_o;
    cmd_bank_o <= ~cmd_bank_o;
    cmd_col_o <= ~cmd_col_o;
    cmd_a12_o <= ~cmd_a12_o;
    cmd_ap_o <= ~cmd_ap_o;
  endtask : idle

  // Called at a rising edge; returns at the edge that takes the command
  // No command timing is broken, so no device reset is ever needed
  task automatic send(input logic [2:0] c, input logic [2:0] b,
                      input logic [9:0] col, input logic a12,
                      input logic ap);
    int e;
    e = cyc;
    if (c == 3'h4) begin
      e = t_rd[b] + AL + TRTP;
      e = (t_act[b] + TRAS > e) ? t_act[b] + TRAS : e;
    end
    if (c == 3'h1) begin
      e = t_pre[b] + TRP;
      e = (t_act[b] + TRC > e) ? t_act[b] + TRC : e;
    end
    if (cyc < e) begin
      idle();
      while (cyc < e) @(posedge clk_sys_i);
    end
    cmd_valid_o <= 1'b1;
    {cmd_o, cmd_bank_o, cmd_col_o, cmd_a12_o, cmd_ap_o} <= {c, b, col, a12, ap};
    do @(posedge clk_sys_i); while (cmd_ready_i !== 1'b1);
    case (c)
      3'h1: t_act[b] = cyc;
      3'h2: t_rd[b] = cyc;
      3'h4: t_pre[b] = cyc;
      default: ;
    endcase
  endtask : send

  // Bit 16 marks a word whose strobe timing is broken on purpose
  task automatic push(input logic [16:0] w);
    wq.push_back(w);
  endtask : push

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wr_valid_o <= 1'b0;
    end else if (!wr_valid_o || wr_ready_i) begin
      if (wr_valid_o) void'(wq.pop_front());
      if (wq.size() != 0 && !wr_stall_i) begin
        wr_valid_o <= 1'b1;
        {wr_viol_o, wr_data_o} <= wq[0];
      end else begin
        wr_valid_o <= 1'b0;
        wr_data_o <= ~wr_data_o;
      end
    end
  end
endmodule : dbp_ctrl_model

/* dbp_burst_test.sv */
// Testbench of the burst engine against a queue model
`timescale 1ns/100ps
`include "dbp_regs.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module dbp_burst_test;
  logic clk_sys_i, sys_rst_i, cmd_valid, cmd_a12, cmd_ap, cmd_ready;
  logic [2:0] cmd, cmd_bank, beat_bank, beat_idx;
  logic [9:0] cmd_col, beat_col;
  logic wr_valid, wr_viol, wr_ready, wr_stall, beat_ready;
  logic [15:0] wr_data, beat_data;
  logic beat_valid, beat_write, beat_last, beat_ap, beat_corrupt;
  logic [3:0] beat_len;
  logic [39:0] exq[$];
  logic [39:0] e;
  logic [16:0] mq[$];
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  int k;

  dbp_burst dbp_burst_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .cmd_valid_i(cmd_valid), .cmd_i(cmd), .cmd_bank_i(cmd_bank),
    .cmd_col_i(cmd_col), .cmd_a12_i(cmd_a12), .cmd_ap_i(cmd_ap),
    .cmd_ready_o(cmd_ready), .wr_valid_i(wr_valid), .wr_data_i(wr_data),
    .wr_viol_i(wr_viol), .wr_ready_o(wr_ready), .beat_valid_o(beat_valid),
    .beat_write_o(beat_write), .beat_bank_o(beat_bank),
    .beat_col_o(beat_col), .beat_idx_o(beat_idx), .beat_len_o(beat_len),
    .beat_last_o(beat_last), .beat_ap_o(beat_ap),
    .beat_corrupt_o(beat_corrupt), .beat_data_o(beat_data),
    .beat_ready_i(beat_ready));

  dbp_ctrl_model dbp_ctrl_model_inst (.clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i), .cmd_valid_o(cmd_valid), .cmd_o(cmd),
    .cmd_bank_o(cmd_bank), .cmd_col_o(cmd_col), .cmd_a12_o(cmd_a12),
    .cmd_ap_o(cmd_ap), .cmd_ready_i(cmd_ready), .wr_stall_i(wr_stall),
    .wr_valid_o(wr_valid), .wr_data_o(wr_data), .wr_viol_o(wr_viol),
    .wr_ready_i(wr_ready));

  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  task automatic results;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  // Consumer and write stream stall at random
  always @(posedge clk_sys_i) begin
    beat_ready <= !sys_rst_i && ($urandom % 4 != 0);
    wr_stall <= ($urandom % 4 == 0);
  end

  always @(posedge clk_sys_i) begin
    if (!sys_rst_i && beat_valid === 1'b1 && beat_ready === 1'b1) begin
      e = (exq.size() != 0) ? exq.pop_front() : ~40'h0;
      `CHK({beat_write, beat_bank, beat_col, beat_idx, beat_len, beat_last,
        beat_ap, beat_corrupt, beat_data}, e)
    end
  end

  task automatic push_word(input logic [16:0] w);
    mq.push_back(w);
    dbp_ctrl_model_inst.push(w);
  endtask : push_word

  task automatic issue(input logic [2:0] c, input logic [2:0] b,
                       input logic [9:0] col, input logic a12,
                       input logic ap);
    logic [3:0] len;
    logic cor;
    logic [16:0] w;
    len = a12 ? `DBP_BL8_BEATS : `DBP_BC4_BEATS;
    cor = 1'b0;
    if (c == 3'h3) while (mq.size() < len) push_word({$urandom % 8 == 0, 16'($urandom)});
    if (c == 3'h2 || c == 3'h3) begin
      for (int i = 0; i < len; i++) begin
        w = (c == 3'h3) ? mq.pop_front() : 17'h0;
        cor |= w[16];
        exq.push_back({c == 3'h3, b, col, 3'(i), len, i == len - 1,
          ap && i == len - 1, cor, w[15:0]});
      end
    end
    dbp_ctrl_model_inst.send(c, b, col, a12, ap);
  endtask : issue

  initial begin
    sys_rst_i = 1'b1;
    beat_ready = 1'b0;
    wr_stall = 1'b0;
    void'($urandom(43));
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(negedge clk_sys_i);
    `CHK({cmd_ready, wr_ready, beat_valid, beat_len}, 7'h68)
    // Overfill the buffer before any write burst drains it
    for (k = 0; k < 20; k++) push_word({$urandom % 8 == 0, 16'($urandom)});
    for (k = 0; k < 200 && wr_ready !== 1'b0; k++) @(posedge clk_sys_i);
    `CHK(wr_ready, 1'b0)
    for (k = 0; k < 60; k++) begin
      issue(3'($urandom % 5), 3'($urandom), 10'($urandom), 1'($urandom),
        1'($urandom));
      if ($urandom % 3 == 0) begin
        dbp_ctrl_model_inst.idle();
        @(posedge clk_sys_i);
      end
    end
    while (mq.size() != 0) issue(3'h3, 3'h5, 10'h3ff, mq.size() >= 8, 1'b1);
    dbp_ctrl_model_inst.idle();
    for (k = 0; k < 500 && exq.size() != 0; k++) @(posedge clk_sys_i);
    repeat (4) @(posedge clk_sys_i);
    `CHK({exq.size() == 0, wr_ready, cmd_ready}, 3'h7)
    results();
  end
endmodule : dbp_burst_test
